// file: src/cisa_defines.svh
`ifndef CISA_DEFINES_SVH
`define CISA_DEFINES_SVH

// register byte offsets on the bus, low eight address bits decoded
`define CISA_OFF_INSTR    8'h00
`define CISA_OFF_PC       8'h04
`define CISA_OFF_STATUS   8'h08
`define CISA_OFF_REG_SEL  8'h0c
`define CISA_OFF_REG_DATA 8'h10
`define CISA_OFF_CYCLES   8'h14

// status register field positions
`define CISA_ST_BUSY      0
`define CISA_ST_COMP      1
`define CISA_ST_UNDEF     2
`define CISA_ST_WRONG     3
`define CISA_ST_FLAG_LSB  4
`define CISA_ST_FLAG_MSB  7

// reset values
`define CISA_RST_COMP     1'b1
`define CISA_RST_PC       32'h0000_0000
`define CISA_RST_FLAGS    4'h0

// program counter arithmetic
`define CISA_PC_AHEAD     32'h0000_0004
`define CISA_INSTR_BYTES  32'h0000_0002
`define CISA_PC_REG       4'hf

// cycle counts of the equivalent full-width instructions
`define CISA_CYC_ALU      1
`define CISA_CYC_BRANCH   3
`define CISA_CYC_LOAD     3
`define CISA_CYC_STORE    2

`endif

// file: src/cisa_pkg.sv
`default_nettype none
package cisa_pkg;

  typedef enum logic [2:0] {
    OP_UNDEF = 3'b000,
    OP_ADD   = 3'b001,
    OP_CMP   = 3'b010,
    OP_MOV   = 3'b011,
    OP_BX    = 3'b100,
    OP_LOAD  = 3'b101,
    OP_STORE = 3'b110
  } op_type;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00,
    SZ_HALF = 2'b01,
    SZ_WORD = 2'b10
  } size_type;

  typedef enum logic [1:0] {
    FSM_IDLE = 2'b00,
    FSM_MEM  = 2'b01,
    FSM_HOLD = 2'b10
  } fsm_type;

  // one decoded instruction
  typedef struct packed {
    op_type op;
    logic [3:0] dst;
    logic [3:0] src_a;
    logic [3:0] src_b;
    logic pc_rel;
    logic [9:0] imm;
    size_type size;
    logic sign_ext;
  } decode_type;

  // request towards memory, data right-justified
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    size_type size;
    logic write;
  } mem_cmd_type;

  typedef struct packed {
    logic [15:0][31:0] rf;
    logic [31:0] pc;
    logic compressed;
    logic [3:0] flags;
    logic undef;
    logic wrong_state;
    logic [15:0] instr;
    fsm_type fsm;
    logic [3:0] cnt;
    logic [7:0] cyc;
    logic [3:0] reg_sel;
    logic [3:0] ld_dst;
    logic ld_sign;
    mem_cmd_type mem;
    logic dp_valid;
    logic dp_write;
    logic dp_word;
    logic [7:0] dp_addr;
    logic [31:0] hrdata;
  } core_state_type;

endpackage
`default_nettype wire

// file: src/cisa_decode.sv
`default_nettype none
module cisa_decode (
  input wire logic [15:0] instr,
  output var cisa_pkg::decode_type dec
);

  logic [1:0] sel;

  // field extraction at the conventional bit positions
  always_comb begin
    dec = '0;
    dec.op = cisa_pkg::OP_UNDEF;
    dec.size = cisa_pkg::SZ_WORD;
    sel = 2'b00;
    if (instr[15:10] == 6'b010001) begin
      // hi-register group: bank flags extend both fields
      dec.dst = {instr[7], instr[2:0]};
      dec.src_a = {instr[7], instr[2:0]};
      dec.src_b = {instr[6], instr[5:3]};
      unique case (instr[9:8])
        2'b00: begin
          if (instr[7] | instr[6]) dec.op = cisa_pkg::OP_ADD;
        end
        2'b01: begin
          if (instr[7] | instr[6]) dec.op = cisa_pkg::OP_CMP;
        end
        2'b10: begin
          if (instr[7] | instr[6]) dec.op = cisa_pkg::OP_MOV;
        end
        2'b11: begin
          // destination bank flag set is not a valid branch form
          if (!instr[7]) dec.op = cisa_pkg::OP_BX;
        end
      endcase
    end else if (instr[15:11] == 5'b01001) begin
      dec.op = cisa_pkg::OP_LOAD;
      dec.dst = {1'b0, instr[10:8]};
      dec.pc_rel = 1'b1;
      dec.imm = {instr[7:0], 2'b00};
    end else if (instr[15:12] == 4'b0101) begin
      // low registers only for base and offset
      dec.dst = {1'b0, instr[2:0]};
      dec.src_a = {1'b0, instr[5:3]};
      dec.src_b = {1'b0, instr[8:6]};
      if (!instr[9]) begin
        // load bit 11, byte bit 10
        dec.op = instr[11] ? cisa_pkg::OP_LOAD : cisa_pkg::OP_STORE;
        dec.size = instr[10] ? cisa_pkg::SZ_BYTE : cisa_pkg::SZ_WORD;
      end else begin
        sel = {instr[10], instr[11]};
        unique case (sel)
          2'b00: begin
            dec.op = cisa_pkg::OP_STORE;
            dec.size = cisa_pkg::SZ_HALF;
          end
          2'b01: begin
            dec.op = cisa_pkg::OP_LOAD;
            dec.size = cisa_pkg::SZ_HALF;
          end
          2'b10: begin
            dec.op = cisa_pkg::OP_LOAD;
            dec.size = cisa_pkg::SZ_BYTE;
            dec.sign_ext = 1'b1;
          end
          2'b11: begin
            dec.op = cisa_pkg::OP_LOAD;
            dec.size = cisa_pkg::SZ_HALF;
            dec.sign_ext = 1'b1;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// file: src/cisa_core.sv
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`include "cisa_defines.svh"
`default_nettype none
module cisa_core #(
  parameter int unsigned ALU_CYCLES = `CISA_CYC_ALU,
  parameter int unsigned BRANCH_CYCLES = `CISA_CYC_BRANCH,
  parameter int unsigned LOAD_CYCLES = `CISA_CYC_LOAD,
  parameter int unsigned STORE_CYCLES = `CISA_CYC_STORE
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic mem_req,
  output var cisa_pkg::mem_cmd_type mem_cmd,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata
);

  // the counter needs one hold cycle, memory ops one memory cycle
  if (ALU_CYCLES < 1 || ALU_CYCLES > 15 || BRANCH_CYCLES < 1 ||
      BRANCH_CYCLES > 15 || LOAD_CYCLES < 2 || LOAD_CYCLES > 15 ||
      STORE_CYCLES < 2 || STORE_CYCLES > 15) begin : bad_cycles
    $error("cycle counts must lie in the range the counter serves");
  end

  cisa_pkg::core_state_type s_r;
  cisa_pkg::core_state_type s_nxt;
  cisa_pkg::decode_type dec;
  logic busy;
  logic wr_go;

  // counter as an operand: address plus 4, bit 0 forced low
  function automatic logic [31:0] pc_operand(input logic [31:0] pc);
    pc_operand = (pc + `CISA_PC_AHEAD) & ~32'h0000_0001;
  endfunction

  function automatic logic [31:0] read_reg(
    input cisa_pkg::core_state_type s,
    input logic [3:0] idx
  );
    read_reg = (idx == `CISA_PC_REG) ? pc_operand(s.pc) : s.rf[idx];
  endfunction

  // width and sign handling of loaded data
  function automatic logic [31:0] extend(
    input logic [31:0] d,
    input cisa_pkg::size_type sz,
    input logic sgn
  );
    unique case (sz)
      cisa_pkg::SZ_BYTE: begin
        extend = sgn ? {{24{d[7]}}, d[7:0]}
                     : {24'h00_0000, d[7:0]};
      end
      cisa_pkg::SZ_HALF: begin
        extend = sgn ? {{16{d[15]}}, d[15:0]}
                     : {16'h0000, d[15:0]};
      end
      default: begin
        extend = d;
      end
    endcase
  endfunction

  // store data trimmed to the access width
  function automatic logic [31:0] trim(
    input logic [31:0] d,
    input cisa_pkg::size_type sz
  );
    unique case (sz)
      cisa_pkg::SZ_BYTE: trim = {24'h00_0000, d[7:0]};
      cisa_pkg::SZ_HALF: trim = {16'h0000, d[15:0]};
      default: trim = d;
    endcase
  endfunction

  function automatic logic [31:0] read_mux(
    input cisa_pkg::core_state_type s,
    input logic [7:0] a
  );
    read_mux = 32'h0000_0000;
    unique case (a)
      `CISA_OFF_INSTR: read_mux = {16'h0000, s.instr};
      `CISA_OFF_PC: read_mux = s.pc;
      `CISA_OFF_STATUS: begin
        read_mux[`CISA_ST_BUSY] = (s.fsm != cisa_pkg::FSM_IDLE);
        read_mux[`CISA_ST_COMP] = s.compressed;
        read_mux[`CISA_ST_UNDEF] = s.undef;
        read_mux[`CISA_ST_WRONG] = s.wrong_state;
        read_mux[`CISA_ST_FLAG_MSB:`CISA_ST_FLAG_LSB] = s.flags;
      end
      `CISA_OFF_REG_SEL: read_mux = {28'h000_0000, s.reg_sel};
      `CISA_OFF_REG_DATA: begin
        read_mux = (s.reg_sel == `CISA_PC_REG) ? s.pc : s.rf[s.reg_sel];
      end
      `CISA_OFF_CYCLES: read_mux = {24'h00_0000, s.cyc};
      default: read_mux = 32'h0000_0000; // unmapped reads as zero
    endcase
  endfunction

  // the instruction written over the bus is decoded straight away
  cisa_decode u_decode (
    .instr(hwdata[15:0]),
    .dec(dec)
  );

  // writes stall while an instruction runs, so software never races it
  assign busy = (s_r.fsm != cisa_pkg::FSM_IDLE);
  assign hreadyout = !(s_r.dp_valid && s_r.dp_write && busy);
  assign hresp = 1'b0;
  assign hrdata = s_r.hrdata;
  assign mem_req = (s_r.fsm == cisa_pkg::FSM_MEM);
  assign mem_cmd = s_r.mem;
  assign wr_go = s_r.dp_valid && s_r.dp_write && s_r.dp_word && !busy;

  // whole next state: bus slave, execution and memory sequencing
  always_comb begin
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] sum;
    logic [32:0] diff;
    logic [31:0] base;
    a = read_reg(s_r, dec.src_a);
    b = read_reg(s_r, dec.src_b);
    sum = a + b;
    diff = {1'b0, a} + {1'b0, ~b} + 33'h0_0000_0001;
    base = pc_operand(s_r.pc) & ~32'h0000_0002;
    s_nxt = s_r;

    // data phase of a register write
    if (wr_go) begin
      unique case (s_r.dp_addr)
        `CISA_OFF_PC: s_nxt.pc = hwdata & ~32'h0000_0001;
        `CISA_OFF_STATUS: begin
          s_nxt.compressed = hwdata[`CISA_ST_COMP];
          s_nxt.flags = hwdata[`CISA_ST_FLAG_MSB:`CISA_ST_FLAG_LSB];
          // error bits clear by writing one
          s_nxt.undef = s_r.undef & ~hwdata[`CISA_ST_UNDEF];
          s_nxt.wrong_state = s_r.wrong_state & ~hwdata[`CISA_ST_WRONG];
        end
        `CISA_OFF_REG_SEL: s_nxt.reg_sel = hwdata[3:0];
        `CISA_OFF_REG_DATA: begin
          if (s_r.reg_sel == `CISA_PC_REG) begin
            s_nxt.pc = hwdata & ~32'h0000_0001;
          end else begin
            s_nxt.rf[s_r.reg_sel] = hwdata;
          end
        end
        default: begin
        end
      endcase
    end

    // an instruction write issues it when the core is idle
    if (wr_go && s_r.dp_addr == `CISA_OFF_INSTR) begin
      s_nxt.instr = hwdata[15:0];
      s_nxt.cyc = 8'h00;
      s_nxt.fsm = cisa_pkg::FSM_HOLD;
      s_nxt.cnt = 4'(ALU_CYCLES - 1);
      if (!s_r.compressed) begin
        // full-width state is served elsewhere, refuse here
        s_nxt.wrong_state = 1'b1;
        s_nxt.fsm = cisa_pkg::FSM_IDLE;
      end else begin
        unique case (dec.op)
          cisa_pkg::OP_ADD, cisa_pkg::OP_MOV: begin
            // flags untouched by add and move
            if (dec.op == cisa_pkg::OP_MOV) begin
              sum = b;
            end
            if (dec.dst == `CISA_PC_REG) begin
              s_nxt.pc = sum & ~32'h0000_0001;
              s_nxt.cnt = 4'(BRANCH_CYCLES - 1);
            end else begin
              s_nxt.rf[dec.dst] = sum;
              s_nxt.pc = s_r.pc + `CISA_INSTR_BYTES;
            end
          end
          cisa_pkg::OP_CMP: begin
            // n z c v from the discarded difference
            s_nxt.flags = {diff[31], (diff[31:0] == 32'h0000_0000),
                           diff[32], (a[31] ^ b[31]) & (a[31] ^ diff[31])};
            s_nxt.pc = s_r.pc + `CISA_INSTR_BYTES;
          end
          cisa_pkg::OP_BX: begin
            // an unaligned branch on the counter is not guarded
            s_nxt.pc = b & ~32'h0000_0001;
            s_nxt.compressed = b[0];
            s_nxt.cnt = 4'(BRANCH_CYCLES - 1);
          end
          cisa_pkg::OP_LOAD, cisa_pkg::OP_STORE: begin
            s_nxt.fsm = cisa_pkg::FSM_MEM;
            s_nxt.pc = s_r.pc + `CISA_INSTR_BYTES;
            s_nxt.ld_dst = dec.dst;
            s_nxt.ld_sign = dec.sign_ext;
            s_nxt.mem.size = dec.size;
            s_nxt.mem.write = (dec.op == cisa_pkg::OP_STORE);
            s_nxt.mem.wdata = trim(s_r.rf[dec.dst], dec.size);
            // pre-indexed, base register is never written
            s_nxt.mem.addr = dec.pc_rel ? base + {22'h00_0000, dec.imm}
                                        : sum;
            s_nxt.cnt = (dec.op == cisa_pkg::OP_STORE)
                      ? 4'(STORE_CYCLES - 1) : 4'(LOAD_CYCLES - 1);
          end
          cisa_pkg::OP_UNDEF: begin
            s_nxt.undef = 1'b1;
            s_nxt.fsm = cisa_pkg::FSM_IDLE;
          end
          default: begin
            s_nxt.undef = 1'b1;
            s_nxt.fsm = cisa_pkg::FSM_IDLE;
          end
        endcase
      end
    end

    // memory wait and hold cycles; slow memory stretches the total
    unique case (s_r.fsm)
      cisa_pkg::FSM_IDLE: begin
      end
      cisa_pkg::FSM_MEM: begin
        s_nxt.cyc = s_r.cyc + 8'h01;
        if (mem_ack) begin
          if (!s_r.mem.write) begin
            s_nxt.rf[s_r.ld_dst] = extend(mem_rdata, s_r.mem.size,
                                          s_r.ld_sign);
          end
          s_nxt.fsm = cisa_pkg::FSM_HOLD;
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      cisa_pkg::FSM_HOLD: begin
        s_nxt.cyc = s_r.cyc + 8'h01;
        if (s_r.cnt == 4'h0) begin
          s_nxt.fsm = cisa_pkg::FSM_IDLE;
        end else begin
          s_nxt.cnt = s_r.cnt - 4'h1;
        end
      end
      default: begin
        s_nxt.fsm = cisa_pkg::FSM_IDLE;
      end
    endcase

    // data phase ends when ready is high; a new address phase may follow
    if (hreadyout) begin
      s_nxt.dp_valid = 1'b0;
    end
    if (hsel && htrans[1] && hready) begin
      s_nxt.dp_valid = 1'b1;
      s_nxt.dp_write = hwrite;
      s_nxt.dp_word = (hsize == 3'b010);
      s_nxt.dp_addr = haddr[7:0];
      if (!hwrite) begin
        s_nxt.hrdata = read_mux(s_r, haddr[7:0]);
      end
    end

    // synchronous reset folded into the next value
    if (!rst_n) begin
      s_nxt = '0;
      s_nxt.pc = `CISA_RST_PC;
      s_nxt.compressed = `CISA_RST_COMP;
      s_nxt.flags = `CISA_RST_FLAGS;
      s_nxt.fsm = cisa_pkg::FSM_IDLE;
      s_nxt.mem.size = cisa_pkg::SZ_WORD;
    end
  end

  always_ff @(posedge clk) begin
    s_r <= s_nxt;
  end

endmodule
`default_nettype wire

// file: testbench/cisa_core_asserts.sv
`default_nettype none
module cisa_core_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic mem_req,
  input wire cisa_pkg::mem_cmd_type mem_cmd,
  input wire logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ip_r, iss_r;
  logic [15:0] ins_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // remember the issued instruction, so a request is tied to its cause
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ip_r <= 1'b0;
      iss_r <= 1'b0;
      ins_r <= 16'h0000;
    end else begin
      iss_r <= ip_r && hready;
      if (ip_r && hready) ins_r <= hwdata[15:0];
      if (hready) ip_r <= hsel && htrans[1] && hwrite && haddr[7:0] == 8'h00;
    end
  end

  req_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_cmd))
    else $error("memory request changed before its answer");
  req_gap_a: assert property (
    mem_req && mem_ack |=> !mem_req [*2])
    else $error("memory request repeated without idle gap");
  req_cause_a: assert property (
    $rose(mem_req) |-> iss_r)
    else $error("memory request without an issued instruction");
  byte_lane_a: assert property (
    mem_req && mem_cmd.write && mem_cmd.size == cisa_pkg::SZ_BYTE |->
    mem_cmd.wdata[31:8] == 24'h0)
    else $error("byte store carries more than the low byte");
  half_lane_a: assert property (
    mem_req && mem_cmd.write && mem_cmd.size == cisa_pkg::SZ_HALF |->
    mem_cmd.wdata[31:16] == 16'h0)
    else $error("halfword store carries upper bits");
  pcrel_word_a: assert property (
    $rose(mem_req) && ins_r[15:11] == 5'b01001 |-> !mem_cmd.write &&
    mem_cmd.size == cisa_pkg::SZ_WORD && mem_cmd.addr[1:0] == 2'b00)
    else $error("counter-relative load not an aligned word read");
  regoff_kind_a: assert property (
    $rose(mem_req) && ins_r[15:12] == 4'b0101 && !ins_r[9] |->
    mem_cmd.write == !ins_r[11] && mem_cmd.size ==
    (ins_r[10] ? cisa_pkg::SZ_BYTE : cisa_pkg::SZ_WORD))
    else $error("register-offset transfer of wrong kind");
  half_kind_a: assert property (
    $rose(mem_req) && ins_r[15:12] == 4'b0101 && ins_r[9] |->
    mem_cmd.write == (ins_r[11:10] == 2'b00) && mem_cmd.size ==
    (ins_r[11:10] == 2'b01 ? cisa_pkg::SZ_BYTE : cisa_pkg::SZ_HALF))
    else $error("halfword group transfer of wrong kind");
  stall_end_a: assert property (
    !hreadyout |-> ##[1:24] hreadyout)
    else $error("bus stall outlasts any instruction");

  cover property ($rose(mem_req) && mem_cmd.write);
  cover property (mem_req && !mem_ack);
  cover property (!hreadyout);
endmodule

bind cisa_core cisa_core_asserts u_chk (.clk(clk), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack));
`default_nettype wire

// file: testbench/cisa_mem_model.sv
`default_nettype none
module cisa_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] wait_cycles,
  input wire logic mem_req,
  input wire cisa_pkg::mem_cmd_type mem_cmd,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] m [0:2047];
  logic [3:0] cnt;
  logic [31:0] last;
  logic [10:0] a;
  function automatic logic [7:0] pat(input logic [10:0] x);
    return x[7:0] ^ {x[10:8], 5'h15};
  endfunction
  // answer after wait_cycles; outside an answer the data line is inverted
  assign a = mem_cmd.addr[10:0];
  assign mem_ack = mem_req && cnt == wait_cycles;
  assign mem_rdata = mem_ack ?
    {m[a + 11'd3], m[a + 11'd2], m[a + 11'd1], m[a]} : ~last;
  // upper lanes of narrow loads carry neighbours, never zeros
  always @(posedge clk) begin
    if (!rst_n || !mem_req || mem_ack) cnt <= 4'h0;
    else cnt <= cnt + 4'h1;
    if (mem_ack) last <= mem_rdata;
    if (mem_ack && mem_cmd.write) begin
      m[a] <= mem_cmd.wdata[7:0];
      if (mem_cmd.size != cisa_pkg::SZ_BYTE) begin
        m[a + 11'd1] <= mem_cmd.wdata[15:8];
      end
      if (mem_cmd.size == cisa_pkg::SZ_WORD) begin
        m[a + 11'd2] <= mem_cmd.wdata[23:16];
        m[a + 11'd3] <= mem_cmd.wdata[31:24];
      end
    end
  end
  initial begin
    last = 32'h0;
    for (int i = 0; i < 2048; i++) m[i] = pat(11'(i));
  end
endmodule
`default_nettype wire

// file: testbench/compact_isa_load_store_decode_tb_top.sv
`default_nettype none
module compact_isa_load_store_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, mem_req, mem_ack;
  logic [31:0] haddr, hwdata, hrdata, mem_rdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] mem_wait;
  cisa_pkg::mem_cmd_type mem_cmd;
  int mismatches, comparisons, cycles;

  cisa_core dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  cisa_mem_model u_mem (.clk(clk), .rst_n(rst_n), .wait_cycles(mem_wait),
    .mem_req(mem_req), .mem_cmd(mem_cmd), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));

  always #20 clk = ~clk;
  // a hang is cut short; the run needs a few hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      test_done();
    end
  end

  function automatic logic [7:0] pat(input logic [10:0] x);
    return x[7:0] ^ {x[10:8], 5'h15};
  endfunction
  function automatic logic [31:0] wd(input logic [10:0] x);
    return {pat(x + 11'd3), pat(x + 11'd2), pat(x + 11'd1), pat(x)};
  endfunction
  task automatic test_done();
    if (mismatches == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s,
      input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // hready is looked at before the edge that samples it
  task automatic rdy();
    @(negedge clk);
    while (hreadyout !== 1'b1) @(negedge clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    rdy();
    @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    rdy();
    q = hrdata;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] q;
    bus(1'b1, a, v, q);
  endtask
  task automatic ck(input string n, input logic [7:0] a,
      input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, q, e);
  endtask
  task automatic sr(input logic [3:0] i, input logic [31:0] v);
    wr(8'h0c, {28'h0, i});
    wr(8'h10, v);
  endtask
  task automatic cr(input logic [3:0] i, input logic [31:0] e);
    wr(8'h0c, {28'h0, i});
    ck($sformatf("r%0d", i), 8'h10, e);
  endtask
  // issue one instruction and wait until the core is idle
  task automatic run(input logic [15:0] ins);
    logic [31:0] q;
    wr(8'h00, {16'h0, ins});
    do bus(1'b0, 8'h08, 32'h0, q); while (q[0] !== 1'b0);
  endtask

  task automatic t_hi();
    sr(4'h8, 32'h8000_0000);
    sr(4'h1, 32'h1);
    run(16'h4588);
    ck("status", 8'h08, 32'h32);
    cr(4'h8, 32'h8000_0000);
    run(16'h4488);
    cr(4'h8, 32'h8000_0001);
    ck("status", 8'h08, 32'h32);
    ck("cycles", 8'h14, 32'h1);
    run(16'h4642);
    cr(4'h2, 32'h8000_0001);
    wr(8'h04, 32'h102);
    run(16'h447b);
    cr(4'h3, 32'h106);
    sr(4'he, 32'h200);
    run(16'h46f7);
    ck("pc", 8'h04, 32'h200);
    ck("cycles", 8'h14, 32'h3);
    sr(4'h5, 32'h10);
    run(16'h44af);
    ck("pc", 8'h04, 32'h214);
    ck("status", 8'h08, 32'h32);
  endtask
  task automatic t_bx();
    sr(4'h4, 32'h301);
    run(16'h4720);
    ck("pc", 8'h04, 32'h300);
    ck("status", 8'h08, 32'h32);
    ck("cycles", 8'h14, 32'h3);
    sr(4'hb, 32'h400);
    run(16'h4758);
    ck("pc", 8'h04, 32'h400);
    run(16'h4488);
    ck("status", 8'h08, 32'h38);
    cr(4'h8, 32'h8000_0001);
    wr(8'h08, 32'ha);
    ck("status", 8'h08, 32'h2);
    // destination bank flag on a branch is refused as undefined
    run(16'h4780);
    ck("status", 8'h08, 32'h6);
    ck("pc", 8'h04, 32'h400);
    wr(8'h08, 32'h6);
    ck("status", 8'h08, 32'h2);
  endtask
  // largest offset, slow memory, next write stalls behind the load
  task automatic t_pcrel();
    mem_wait <= 4'h2;
    wr(8'h04, 32'h102);
    wr(8'h00, 32'h4bff);
    cr(4'h3, wd(11'h500));
    ck("cycles", 8'h14, 32'h5);
    mem_wait <= 4'h0;
  endtask
  task automatic t_regoff();
    sr(4'h0, 32'ha1b2_c3d4);
    sr(4'h1, 32'h200);
    sr(4'h2, 32'h10);
    sr(4'h6, 32'h13);
    sr(4'h5, 32'hffff_ffff);
    run(16'h5088);
    run(16'h588c);
    ck("cycles", 8'h14, 32'h3);
    cr(4'h4, 32'ha1b2_c3d4);
    cr(4'h1, 32'h200);
    run(16'h5588);
    chk("bytes", {u_mem.m[11'h214], u_mem.m[11'h213],
      u_mem.m[11'h212], 8'h0}, {pat(11'h214), 8'hd4, 8'hb2, 8'h0});
    run(16'h5d8d);
    cr(4'h5, 32'hd4);
  endtask
  task automatic t_half();
    sr(4'h7, 32'h1234_8765);
    run(16'h528f);
    chk("half", {8'h0, u_mem.m[11'h212], u_mem.m[11'h211],
      u_mem.m[11'h210]}, 32'h00b2_8765);
    ck("cycles", 8'h14, 32'h2);
    run(16'h5a8c);
    cr(4'h4, 32'h8765);
    run(16'h5e8c);
    cr(4'h4, 32'hffff_8765);
    run(16'h578c);
    cr(4'h4, 32'hffff_ffd4);
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    mem_wait = 4'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ck("status", 8'h08, 32'h2);
    t_hi();
    t_bx();
    t_pcrel();
    t_regoff();
    t_half();
    test_done();
  end
endmodule
`default_nettype wire
